// ---- byte_op_execute_unit.v ----
// byte operation execute unit with ahb-lite register access
//
// Function
// - any instruction that writes the program counter forces pc bit 8 to zero.
// - a read-modify-write of the port register takes its source from the pin levels, not the latch.
// - the direction latch load with file operand 6 copies the accumulator into the port direction latches.
// - a direction bit of one floats its pin and a zero lets the pin drive.
// - a marked file write to the timer count register clears the prescaler when it is assigned to the timer.
// - add accumulator to file sums both in one cycle and updates carry, nibble overflow and zero.
// - a destination bit of zero sends the result to the accumulator, one sends it back to the file register.
// - and literal with accumulator ands the 8-bit literal into the accumulator and updates only zero.
// - an instruction cycle is four oscillator periods, and a program counter change takes two cycles.
`timescale 1ns/10ps
`default_nettype none
`include "byte_op_defines.vh"

module byte_op_execute_unit (
  input  wire        i_mclk,
  input  wire        i_rst_n,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire [5:0]  i_pin_level,
  output wire [5:0]  o_pin_out,
  output wire [5:0]  o_pin_oe_n,
  output reg         o_prescaler_clr
);
  localparam [2:0] S_IDLE  = 3'b001;
  localparam [2:0] S_ARM   = 3'b010;
  localparam [2:0] S_FLUSH = 3'b100;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  reg  [1:0]  osc_cnt_ff;
  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg  [11:0] instr_ff;
  reg  [7:0]  acc_ff;
  reg         flag_c_ff;
  reg         flag_dc_ff;
  reg         flag_z_ff;
  reg  [9:0]  pc_ff;
  reg  [5:0]  dir_ff;
  reg         psa_timer_ff;
  reg  [5:0]  pin_s1_ff;
  reg  [5:0]  pin_s2_ff;
  reg  [5:0]  pin_s3_ff;
  reg  [5:0]  pin_lvl_ff;
  reg         dph_valid_ff;
  reg         dph_write_ff;
  reg  [7:0]  dph_addr_ff;
  wire [255:0] file_flat;

  // ----------------------------------------------------------------------
  // instruction cycle divider
  // ----------------------------------------------------------------------
  wire icyc_en = ({30'h0, osc_cnt_ff} == `OSC_PER_ICYCLE - 1);
  // one enable pulse every four oscillator periods
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_cnt_ff <= 2'h0;
    end else begin
      osc_cnt_ff <= osc_cnt_ff + 2'h1;
    end
  end

  // ----------------------------------------------------------------------
  // pin input synchroniser
  // ----------------------------------------------------------------------
  wire [5:0] pin_agree = ~(pin_s2_ff ^ pin_s3_ff);
  // three stages, level accepted once stages two and three agree
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1_ff  <= 6'h00;
      pin_s2_ff  <= 6'h00;
      pin_s3_ff  <= 6'h00;
      pin_lvl_ff <= 6'h00;
    end else begin
      pin_s1_ff  <= i_pin_level;
      pin_s2_ff  <= pin_s1_ff;
      pin_s3_ff  <= pin_s2_ff;
      pin_lvl_ff <= (pin_agree & pin_s3_ff) | (~pin_agree & pin_lvl_ff);
    end
  end

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  wire       dst_file  = instr_ff[5];
  wire [4:0] f_field   = instr_ff[4:0];
  wire       op_add    = (instr_ff[11:6] == `OPC_ADD_ACC_FILE);
  wire       op_andf   = (instr_ff[11:6] == `OPC_AND_ACC_FILE);
  wire       op_bclr   = (instr_ff[11:8] == `OPC_BIT_CLEAR);
  wire       op_andl   = (instr_ff[11:8] == `OPC_AND_LITERAL);
  wire       op_dirl   = (instr_ff[11:3] == `OPC_DIR_LOAD) &&
                         (instr_ff[2:0] == `DIR_LOAD_PORT_F);
  wire [7:0] ptr_val   = file_flat[`FA_POINTER*8 +: 8];
  wire [4:0] fsel      = (f_field == `FA_INDIRECT) ? ptr_val[4:0] : f_field;
  wire [7:0] stat_byte = {5'h00, flag_z_ff, flag_dc_ff, flag_c_ff};
  // file read view, port reads come from the pins; all sources are arguments so callers track them
  function [7:0] file_read;
    input [4:0]   idx;
    input [7:0]   pcl;
    input [7:0]   stat;
    input [5:0]   pins;
    input [255:0] cells;
    begin
      if (idx == `FA_INDIRECT) begin
        file_read = 8'h00;
      end else if (idx == `FA_PCL) begin
        file_read = pcl;
      end else if (idx == `FA_STATUS) begin
        file_read = stat;
      end else if (idx == `FA_PORT) begin
        file_read = {2'h0, pins};
      end else begin
        file_read = cells[idx*8 +: 8];
      end
    end
  endfunction
  wire [7:0] fval = file_read(fsel, pc_ff[7:0], stat_byte, pin_lvl_ff, file_flat);

  // ----------------------------------------------------------------------
  // alu
  // ----------------------------------------------------------------------
  wire [1:0] alu_op   = op_add ? `ALU_ADD : (op_bclr ? `ALU_BCLR : `ALU_AND);
  wire [7:0] alu_opnd = op_andl ? instr_ff[7:0] : fval;
  wire [7:0] alu_res;
  wire       alu_c;
  wire       alu_dc;
  wire       alu_z;
  byte_alu u_alu (
    .i_op    (alu_op),
    .i_acc   (acc_ff),
    .i_opnd  (alu_opnd),
    .i_bit   (instr_ff[7:5]),
    .o_res   (alu_res),
    .o_carry (alu_c),
    .o_half  (alu_dc),
    .o_zero  (alu_z)
  );

  // ----------------------------------------------------------------------
  // execute strobes
  // ----------------------------------------------------------------------
  wire exec_now = (state_ff == S_ARM) && icyc_en;
  wire acc_wr   = exec_now && (op_andl || ((op_add || op_andf) && !dst_file));
  wire file_wr  = exec_now && (op_bclr || ((op_add || op_andf) && dst_file));
  wire pc_wr    = file_wr && (fsel == `FA_PCL);
  wire stat_wr  = file_wr && (fsel == `FA_STATUS);
  wire z_upd    = exec_now && (op_add || op_andf || op_andl);

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  wire bus_wr      = dph_valid_ff && dph_write_ff;
  wire instr_start = bus_wr && (dph_addr_ff == `OFS_INSTR) && (state_ff == S_IDLE);
  // next state: wait for the cycle edge, then an extra cycle after a pc change
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE: begin
        if (instr_start) begin
          nxt_state = S_ARM;
        end
      end
      S_ARM: begin
        if (icyc_en) begin
          nxt_state = pc_wr ? S_FLUSH : S_IDLE;
        end
      end
      S_FLUSH: begin
        if (icyc_en) begin
          nxt_state = S_IDLE;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end
  // state and instruction latch
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= S_IDLE;
      instr_ff <= 12'h000;
    end else begin
      state_ff <= nxt_state;
      if (instr_start) begin
        instr_ff <= hwdata[11:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // accumulator, flags, program counter, direction latches
  // ----------------------------------------------------------------------
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_ff     <= `ACC_RST;
      flag_c_ff  <= 1'b0;
      flag_dc_ff <= 1'b0;
      flag_z_ff  <= 1'b0;
      pc_ff      <= `PC_RST;
      dir_ff     <= `DIR_RST;
    end else begin
      if (acc_wr) begin
        acc_ff <= alu_res;
      end else if (bus_wr && (dph_addr_ff == `OFS_ACC)) begin
        acc_ff <= hwdata[7:0];
      end
      // status written as a file first, flag results override it
      if (stat_wr) begin
        flag_c_ff  <= alu_res[`ST_C];
        flag_dc_ff <= alu_res[`ST_DC];
        flag_z_ff  <= alu_res[`ST_Z];
      end
      if (exec_now && op_add) begin
        flag_c_ff  <= alu_c;
        flag_dc_ff <= alu_dc;
      end
      if (z_upd) begin
        flag_z_ff <= alu_z;
      end
      if (pc_wr) begin
        pc_ff <= {pc_ff[9], 1'b0, alu_res};
      end else if (exec_now) begin
        pc_ff <= pc_ff + 10'h001;
      end
      if (exec_now && op_dirl) begin
        dir_ff <= acc_ff[5:0];
      end
    end
  end

  // direction bit one floats the pin
  assign o_pin_oe_n = dir_ff;
  assign o_pin_out  = file_flat[`FA_PORT*8 +: 6];

  // ----------------------------------------------------------------------
  // prescaler clear and control
  // ----------------------------------------------------------------------
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prescaler_clr <= 1'b0;
      psa_timer_ff    <= `CTRL_RST;
    end else begin
      o_prescaler_clr <= file_wr && (fsel == `FA_TIMER) && psa_timer_ff;
      if (bus_wr && (dph_addr_ff == `OFS_CTRL)) begin
        psa_timer_ff <= hwdata[`CTRL_PSA_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // file register cells
  // ----------------------------------------------------------------------
  wire       bus_file_wr = bus_wr && dph_addr_ff[`FILE_WIN_BIT];
  wire [4:0] bus_idx     = dph_addr_ff[6:2];
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_cell
      reg [7:0] cell_ff;
      // execute write wins over a bus write to the same cell
      always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          cell_ff <= 8'h00;
        end else if (file_wr && (fsel == gi)) begin
          cell_ff <= alu_res;
        end else if (bus_file_wr && (bus_idx == gi)) begin
          cell_ff <= hwdata[7:0];
        end
      end
      assign file_flat[gi*8 +: 8] = cell_ff;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------------
  wire       addr_take = hsel && hready && htrans[1];
  wire [7:0] a_ofs     = haddr[7:0];
  reg  [31:0] rd_mux;
  // read data chosen in the address phase
  always @* begin
    if (a_ofs[`FILE_WIN_BIT]) begin
      rd_mux = {24'h000000, file_read(a_ofs[6:2], pc_ff[7:0], stat_byte, pin_lvl_ff, file_flat)};
    end else if (a_ofs == `OFS_INSTR) begin
      rd_mux = {20'h00000, instr_ff};
    end else if (a_ofs == `OFS_ACC) begin
      rd_mux = {24'h000000, acc_ff};
    end else if (a_ofs == `OFS_CTRL) begin
      rd_mux = {31'h00000000, psa_timer_ff};
    end else if (a_ofs == `OFS_STAT) begin
      rd_mux = {23'h000000, (state_ff != S_IDLE), 5'h00, flag_z_ff, flag_dc_ff, flag_c_ff};
    end else if (a_ofs == `OFS_PC) begin
      rd_mux = {22'h000000, pc_ff};
    end else if (a_ofs == `OFS_DIR) begin
      rd_mux = {26'h0000000, dir_ff};
    end else if (a_ofs == `OFS_LATCH) begin
      rd_mux = {24'h000000, file_flat[`FA_PORT*8 +: 8]};
    end else begin
      rd_mux = 32'h00000000;
    end
  end
  // address phase capture and registered read data
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dph_valid_ff <= 1'b0;
      dph_write_ff <= 1'b0;
      dph_addr_ff  <= 8'h00;
      hrdata       <= 32'h00000000;
    end else if (hready) begin
      dph_valid_ff <= addr_take;
      dph_write_ff <= hwrite;
      dph_addr_ff  <= a_ofs;
      if (addr_take && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule // byte_op_execute_unit

`default_nettype wire

// ---- byte_op_defines.vh ----
// constants shared by the byte operation execute unit and its alu
`ifndef BYTE_OP_DEFINES_VH
`define BYTE_OP_DEFINES_VH

// ----------------------------------------------------------------------
// bus register byte offsets
// ----------------------------------------------------------------------
`define OFS_INSTR       8'h00
`define OFS_ACC         8'h04
`define OFS_CTRL        8'h08
`define OFS_STAT        8'h0c
`define OFS_PC          8'h10
`define OFS_DIR         8'h14
`define OFS_LATCH       8'h18
`define FILE_WIN_BIT    7

// ----------------------------------------------------------------------
// bus register fields and reset values
// ----------------------------------------------------------------------
`define CTRL_PSA_BIT    0
`define CTRL_RST        1'b1
`define STAT_BUSY_BIT   8
`define PC_RST          10'h000
`define DIR_RST         6'h3f
`define ACC_RST         8'h00

// ----------------------------------------------------------------------
// file register addresses and status flag positions
// ----------------------------------------------------------------------
`define FA_INDIRECT     5'h00
`define FA_TIMER        5'h01
`define FA_PCL          5'h02
`define FA_STATUS       5'h03
`define FA_POINTER      5'h04
`define FA_PORT         5'h06
`define ST_C            0
`define ST_DC           1
`define ST_Z            2
`define PC_FORCED_BIT   8

// ----------------------------------------------------------------------
// opcode fields
// ----------------------------------------------------------------------
`define OPC_ADD_ACC_FILE  6'h07
`define OPC_AND_ACC_FILE  6'h05
`define OPC_BIT_CLEAR     4'h4
`define OPC_AND_LITERAL   4'he
`define OPC_DIR_LOAD      9'h000
`define DIR_LOAD_PORT_F   3'h6

// ----------------------------------------------------------------------
// alu operation select
// ----------------------------------------------------------------------
`define ALU_ADD         2'h0
`define ALU_AND         2'h1
`define ALU_BCLR        2'h2

// ----------------------------------------------------------------------
// timing: oscillator periods per instruction cycle
// ----------------------------------------------------------------------
`define OSC_PER_ICYCLE  4

`endif

// ---- byte_alu.v ----
// byte alu for add, and and bit clear with flag results
`timescale 1ns/10ps
`default_nettype none
`include "byte_op_defines.vh"

module byte_alu (
  input  wire [1:0] i_op,
  input  wire [7:0] i_acc,
  input  wire [7:0] i_opnd,
  input  wire [2:0] i_bit,
  output reg  [7:0] o_res,
  output reg        o_carry,
  output reg        o_half,
  output wire       o_zero
);

  reg [8:0] sum9;
  reg [4:0] sum5;

  // result and carries for the selected operation
  always @* begin
    sum9    = {1'b0, i_acc} + {1'b0, i_opnd};
    sum5    = {1'b0, i_acc[3:0]} + {1'b0, i_opnd[3:0]};
    o_carry = sum9[8];
    o_half  = sum5[4];
    if (i_op == `ALU_ADD) begin
      o_res = sum9[7:0];
    end else if (i_op == `ALU_BCLR) begin
      o_res = i_opnd & ~(8'h01 << i_bit);
    end else begin
      o_res = i_acc & i_opnd;
    end
  end

  assign o_zero = (o_res == 8'h00);

endmodule // byte_alu

`default_nettype wire

// ---- byte_op_execute_unit_monitor.sv ----
// port checker for the byte operation execute unit
`timescale 1ns/10ps
`default_nettype none
`include "byte_op_defines.vh"
module byte_op_execute_unit_monitor (
  input wire logic        i_mclk,
  input wire logic        i_rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic [5:0]  o_pin_out,
  input wire logic [5:0]  o_pin_oe_n,
  input wire logic        o_prescaler_clr
);
  logic [3:0] quiet_ff;
  wire        take_w = hsel & hready & htrans[1] & hwrite;
  wire        take_r = hsel & hready & htrans[1] & ~hwrite;
  // cycles since the last write request, saturating
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n)
      quiet_ff <= 4'hf;
    else if (take_w)
      quiet_ff <= 4'h0;
    else if (quiet_ff != 4'hf)
      quiet_ff <= quiet_ff + 4'h1;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  property p_bus_okay; hreadyout && !hresp; endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("slave stalled or refused");
  property p_clr_pulse; o_prescaler_clr |=> !o_prescaler_clr; endproperty
  a_clr_pulse: assert property (p_clr_pulse) else $error("clear longer than one clock");
  property p_clr_cause; o_prescaler_clr |-> quiet_ff < 4'h9; endproperty
  a_clr_cause: assert property (p_clr_cause) else $error("clear without instruction");
  property p_dir_hold; quiet_ff > 4'h9 |-> $stable(o_pin_oe_n); endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction moved while idle");
  property p_latch_hold; quiet_ff > 4'h9 |-> $stable(o_pin_out); endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch moved while idle");
  property p_reset_vals;
    $rose(i_rst_n) |-> o_pin_oe_n == `DIR_RST && o_pin_out == 6'h00 && !o_prescaler_clr;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad value after reset");
  property p_dir_read;
    take_r && haddr[7:0] == `OFS_DIR |=> hrdata == {26'h0, $past(o_pin_oe_n)};
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction readback wrong");
  property p_latch_read;
    take_r && haddr[7:0] == `OFS_LATCH |=> hrdata[5:0] == $past(o_pin_out);
  endproperty
  a_latch_read: assert property (p_latch_read) else $error("latch readback wrong");
endmodule // byte_op_execute_unit_monitor

bind byte_op_execute_unit byte_op_execute_unit_monitor byte_op_execute_unit_monitor_inst (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n), .o_prescaler_clr(o_prescaler_clr));
`default_nettype wire

// ---- testbench.sv ----
// self-checking testbench for the byte operation execute unit
`timescale 1ns/10ps
`default_nettype none
`include "byte_op_defines.vh"
module testbench;
  logic        i_mclk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [5:0]  i_pin_level = 6'h00;
  wire         hreadyout;
  wire         hresp;
  wire  [31:0] hrdata;
  wire  [5:0]  o_pin_out;
  wire  [5:0]  o_pin_oe_n;
  wire         o_prescaler_clr;
  int          num_errors = 0;
  int          comparisons = 0;
  int          pulses = 0;
  int          cyc = 0;
  int          pulse_cyc = 0;
  logic [31:0] seed = 32'h7702;
  logic [9:0]  pc_m = 10'h000;
  logic [2:0]  fl_m;
  byte_op_execute_unit byte_op_execute_unit_inst (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .i_pin_level(i_pin_level),
    .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n), .o_prescaler_clr(o_prescaler_clr));
  initial begin
    forever #2 i_mclk = ~i_mclk;
  end
  // count prescaler clear pulses and note the clock of the last one
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (o_prescaler_clr === 1'b1) begin
      pulses <= pulses + 1;
      pulse_cyc <= cyc;
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // sum with flags as {z, dc, c, sum}
  function automatic logic [10:0] add_exp(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return {s[7:0] == 8'h00, {1'b0, a[3:0]} + {1'b0, b[3:0]} > 5'h0f, s[8], s[7:0]};
  endfunction
  task automatic results();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // wait for hready under a bound
  task automatic edge_wait();
    int n;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (n >= 64) begin
      num_errors++;
      results();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    edge_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_wait();
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  // issue one instruction and poll busy until it clears
  task automatic exec(input logic [11:0] op);
    logic [31:0] r;
    int n;
    wr(`OFS_INSTR, {20'h0, op});
    n = 0;
    do begin
      bus(1'b0, `OFS_STAT, 32'h0, r);
      n++;
    end while (r[`STAT_BUSY_BIT] !== 1'b0 && n < 32);
    if (n >= 32) begin
      num_errors++;
      results();
    end
    pc_m = pc_m + 10'h001;
  endtask
  initial begin
    logic [31:0] r;
    logic [31:0] e;
    logic [7:0]  a;
    logic [7:0]  v;
    logic [7:0]  res;
    logic [4:0]  f;
    logic [2:0]  b;
    logic [1:0]  k;
    logic        d;
    logic [10:0] s;
    logic [7:0]  ra [5];
    logic [13:0] pt [6];
    int          p0;
    int          c0;
    ra = '{8'h04, 8'h08, 8'h10, 8'h14, 8'h40};
    pt = '{14'h31e1, 14'h11c1, 14'h01e1, 14'h3161, 14'h3400, 14'h1141};
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    // reset values and an unmapped place
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 32'h0, r);
      chk(r, (i == 1) ? 32'h1 : (i == 3) ? 32'h3f : 32'h0);
    end
    // random byte operations, corner sums first
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      a = (i == 0) ? 8'hff : (i == 1) ? 8'h0f : seed[7:0];
      v = (i < 2) ? 8'h01 : seed[15:8];
      f = {1'b0, seed[19:16]} + 5'h08;
      b = seed[22:20];
      d = seed[23];
      k = (i < 2) ? 2'h0 : seed[25:24];
      wr(`OFS_ACC, {24'h0, a});
      wr({1'b1, f, 2'b00}, {24'h0, v});
      s = add_exp(a, v);
      case (k)
        2'h0: exec({`OPC_ADD_ACC_FILE, d, f});
        2'h1: exec({`OPC_AND_ACC_FILE, d, f});
        2'h2: exec({`OPC_AND_LITERAL, v});
        default: exec({`OPC_BIT_CLEAR, b, f});
      endcase
      res = (k == 2'h0) ? s[7:0] : (k == 2'h3) ? v & ~(8'h01 << b) : a & v;
      if (k == 2'h0)
        fl_m = s[10:8];
      else if (k != 2'h3)
        fl_m[2] = (res == 8'h00);
      d = (k == 2'h3) | (d & (k != 2'h2));
      bus(1'b0, `OFS_ACC, 32'h0, r);
      chk(r, {24'h0, d ? a : res});
      bus(1'b0, {1'b1, f, 2'b00}, 32'h0, r);
      chk(r, {24'h0, d ? res : v});
      bus(1'b0, `OFS_STAT, 32'h0, r);
      chk({29'h0, r[2:0]}, {29'h0, fl_m});
    end
    // direction load, a wrong operand first
    seed = lfsr(seed);
    wr(`OFS_ACC, {24'h0, seed[7:0]});
    exec(12'h005);
    chk({26'h0, o_pin_oe_n}, 32'h3f);
    exec(12'h006);
    chk({26'h0, o_pin_oe_n}, {26'h0, seed[5:0]});
    bus(1'b0, `OFS_DIR, 32'h0, r);
    chk(r, {26'h0, seed[5:0]});
    // bit clear on the port takes the pins as source
    wr({1'b1, `FA_PORT, 2'b00}, 32'hff);
    i_pin_level <= seed[13:8] & 6'h2a;
    repeat (8) @(posedge i_mclk);
    b = seed[18:16] % 3'h6;
    exec({`OPC_BIT_CLEAR, b, `FA_PORT});
    chk({26'h0, o_pin_out}, {26'h0, seed[13:8] & 6'h2a & ~(6'h01 << b)});
    bus(1'b0, `OFS_LATCH, 32'h0, r);
    chk(r, {26'h0, seed[13:8] & 6'h2a & ~(6'h01 << b)});
    // prescaler clear by opcode, destination and assignment
    wr({1'b1, `FA_POINTER, 2'b00}, 32'h01);
    for (int i = 0; i < 6; i++) begin
      wr(`OFS_CTRL, {31'h0, pt[i][12]});
      p0 = pulses;
      exec(pt[i][11:0]);
      repeat (2) @(posedge i_mclk);
      chk(pulses - p0, {31'h0, pt[i][13]});
      // executions only land on instruction cycle edges, so pulses sit a whole number of cycles apart
      if (i == 0)
        c0 = pulse_cyc;
      else if (pt[i][13])
        chk((pulse_cyc - c0) % `OSC_PER_ICYCLE, 32'h0);
    end
    // no-ops until pc bit 8 is set, then a pc low write
    while (pc_m[8] == 1'b0)
      exec(12'h000);
    bus(1'b0, `OFS_PC, 32'h0, r);
    chk(r, {22'h0, pc_m});
    wr(`OFS_ACC, 32'h0);
    e = {22'h0, pc_m[9], 1'b0, pc_m[7:0]};
    exec({`OPC_ADD_ACC_FILE, 1'b1, `FA_PCL});
    bus(1'b0, `OFS_PC, 32'h0, r);
    chk(r, e);
    results();
  end
endmodule // testbench
`default_nettype wire
